// ==== urb_params.svh ====
// register offsets, field positions, reset values and frame constants of the receive buffer
`ifndef URB_PARAMS_SVH
`define URB_PARAMS_SVH
// ==========================================
// register offsets
`define URB_OFS_STATUS 2'h0
`define URB_OFS_CTRL_B 2'h1
`define URB_OFS_CTRL_C 2'h2
`define URB_OFS_DATA 2'h3
// ==========================================
// serial_status_reg fields
`define URB_ST_RXC 7
`define URB_ST_FRAME_ERR 4
`define URB_ST_OVERRUN 3
`define URB_ST_PAR_ERR 2
// ==========================================
// serial_control_reg_b fields
`define URB_CB_RX_IRQ_EN 7
`define URB_CB_RX_ENABLE 4
`define URB_CB_CSZ2 2
`define URB_CB_RX_NINTH 1
`define URB_CB_TX_NINTH 0
// ==========================================
// serial_control_reg_c fields
`define URB_CC_PAR_ENABLE 5
`define URB_CC_PAR_ODD 4
`define URB_CC_STOP_BITS 3
`define URB_CC_CSZ_HI 2
`define URB_CC_CSZ_LO 1
// ==========================================
// reset values and frame constants
`define URB_CB_RESET 8'h00
`define URB_CC_RESET 8'h06
`define URB_CSZ_NINE 3'h7
`define URB_MIN_BITS 4'h5
`define URB_NINE_BITS 4'h9
`endif

// ==== urb_pkg.sv ====
// types shared by the receive buffer logic
package urb_pkg;
  // receive frame sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_PAR, ST_STOP} urb_state_type;
  // one receive buffer entry: character plus its error flags
  typedef struct packed {
    logic [8:0] data;
    logic frame_err;
    logic overrun;
    logic par_err;
  } urb_entry_type;
endpackage

// ==== urb_rx_buffer.sv ====
// receive shift register, two-entry receive buffer, status and register port
//
// Behaviour
// RQ1: software reads ninth bit and errors before the low data byte.
// RQ2: reading the data location pops the buffer; flags follow next entry.
// RQ3: receive-complete reads one exactly while unread data are buffered.
// RQ4: clearing receiver enable flushes the buffer at once.
// RQ5: interrupt stays high while enabled and receive-complete is one.
// RQ6: frame, overrun and parity errors are stored per buffer entry.
// RQ7: software writes to error flag positions are ignored.
// RQ8: software writes zero to error flag positions of status.
// RQ9: error flags never raise an interrupt.
// RQ10: frame error reflects only the first stop bit of the head entry.
// RQ11: overrun sets when buffer and shift register full and start arrives.
// RQ12: overrun clears once a frame moves from shift register to buffer.
// RQ13: parity error reads zero while parity checking is disabled.
// RQ14: checker runs when parity enable set; odd select picks sense.
// RQ15: parity error set if head failed check with checking enabled.
// RQ16: parity error holds until the data location is read.
// RQ17: disabling the receiver abandons any frame in progress immediately.
// RQ18: disabled receiver releases the serial input pin.
// RQ19: software reads status before data because data read pops.
// RQ20: software flushes by reading data until receive-complete clears.
// RQ21: on the first stop bit the frame moves toward the buffer.
// RQ22: a second stop bit is ignored.
// RQ23: unused upper data bits read as zero.
// RQ24: buffer holds two full entries fed by a separate shift register.
// RQ25: odd select zero means even parity, one means odd parity.
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "urb_params.svh"
module urb_rx_buffer #(
  parameter int DEPTH = 2
) (
  input wire logic SYS_CLK, // system clock, 50 MHz
  input wire logic SRST, // synchronous reset, active high
  input wire logic [1:0] ADDR, // register address
  input wire logic [7:0] WDATA, // register write data
  input wire logic WR, // write strobe
  input wire logic RD, // read strobe
  input wire logic START_DET, // pulse: validated start bit seen
  input wire logic BIT_STB, // pulse: one voted bit available
  input wire logic BIT_VAL, // voted value of that bit
  output logic [7:0] RDATA, // read data, cycle after the read strobe
  output logic RX_IRQ, // receive complete interrupt request
  output logic RX_PIN_OVERRIDE // high while receiver owns the input pin
);
  import urb_pkg::*;

  // ==========================================
  // state
  urb_state_type state_q, state_d;
  logic [3:0] bit_cnt_q, bit_cnt_d;
  logic [8:0] sh_q, sh_d;
  logic par_err_q, par_err_d;
  urb_entry_type hold_q, hold_d;
  logic hold_full_q, hold_full_d;
  logic ovr_pend_q, ovr_pend_d;
  urb_entry_type fifo_q [DEPTH];
  urb_entry_type fifo_d [DEPTH];
  logic [$clog2(DEPTH)-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [$clog2(DEPTH):0] cnt_q, cnt_d;
  logic [7:0] ctrl_b_q, ctrl_b_d, ctrl_c_q, ctrl_c_d;
  logic [7:0] rdata_d;
  logic irq_d;
  logic rx_en, par_en, nonempty, push, pop;
  logic [2:0] csz;
  logic [3:0] nbits;
  urb_entry_type head;

  assign rx_en = ctrl_b_q[`URB_CB_RX_ENABLE];
  assign par_en = ctrl_c_q[`URB_CC_PAR_ENABLE];
  assign csz = {ctrl_b_q[`URB_CB_CSZ2], ctrl_c_q[`URB_CC_CSZ_HI], ctrl_c_q[`URB_CC_CSZ_LO]};
  assign nbits = (csz == `URB_CSZ_NINE) ? `URB_NINE_BITS : (`URB_MIN_BITS + {2'h0, csz[1:0]});
  assign nonempty = (cnt_q != '0);
  assign head = fifo_q[rd_ptr_q];
  // data read pops the head entry
  assign pop = RD && (ADDR == `URB_OFS_DATA) && nonempty && rx_en; // see RQ2
  // held frame enters the buffer whenever a slot is free after this cycle's pop
  assign push = hold_full_q && rx_en && ((cnt_q != DEPTH[$clog2(DEPTH):0]) || pop); // see RQ24

  // ==========================================
  // frame sequencer: assembles one character in the shift register
  always_comb begin
    state_d = state_q;
    bit_cnt_d = bit_cnt_q;
    sh_d = sh_q;
    par_err_d = par_err_q;
    hold_d = hold_q;
    hold_full_d = hold_full_q && !push;
    ovr_pend_d = ovr_pend_q && !push; // see RQ12
    case (state_q)
      ST_IDLE: begin
        if (START_DET) begin
          if (hold_full_q && !push) begin
            // shift register still occupied, buffer full: frame is lost
            ovr_pend_d = 1'b1; // see RQ11
          end else begin
            state_d = ST_DATA;
            bit_cnt_d = 4'h0;
            sh_d = 9'h000; // unused upper bits stay zero, see RQ23
          end
        end
      end
      ST_DATA: begin
        if (BIT_STB) begin
          sh_d[bit_cnt_q] = BIT_VAL;
          bit_cnt_d = bit_cnt_q + 4'h1;
          if (bit_cnt_q + 4'h1 == nbits) begin
            state_d = par_en ? ST_PAR : ST_STOP;
            par_err_d = 1'b0;
          end
        end
      end
      ST_PAR: begin
        if (BIT_STB) begin
          // even sense: total ones even; odd select inverts, see RQ14 and RQ25
          par_err_d = (^sh_q) ^ BIT_VAL ^ ctrl_c_q[`URB_CC_PAR_ODD];
          state_d = ST_STOP;
        end
      end
      ST_STOP: begin
        if (BIT_STB) begin
          // first stop bit completes the frame; any second one is ignored
          hold_d.data = sh_q; // see RQ21
          hold_d.frame_err = !BIT_VAL; // see RQ10
          hold_d.par_err = par_err_q && par_en; // see RQ15
          hold_d.overrun = 1'b0;
          hold_full_d = 1'b1;
          state_d = ST_IDLE; // see RQ22
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (!rx_en) begin
      // disable is immediate: the frame in flight is dropped
      state_d = ST_IDLE; // see RQ17
      hold_full_d = 1'b0;
      ovr_pend_d = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      sh_q <= 9'h000;
      par_err_q <= 1'b0;
      hold_q <= '0;
      hold_full_q <= 1'b0;
      ovr_pend_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bit_cnt_q <= bit_cnt_d;
      sh_q <= sh_d;
      par_err_q <= par_err_d;
      hold_q <= hold_d;
      hold_full_q <= hold_full_d;
      ovr_pend_q <= ovr_pend_d;
    end
  end

  // ==========================================
  // receive buffer: entries carry their own error flags
  always_comb begin
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    cnt_d = cnt_q;
    for (int i = 0; i < DEPTH; i++) begin
      fifo_d[i] = fifo_q[i];
    end
    if (push) begin
      fifo_d[wr_ptr_q] = hold_q; // see RQ6
      fifo_d[wr_ptr_q].overrun = ovr_pend_q;
      wr_ptr_d = (wr_ptr_q == $clog2(DEPTH)'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
    end
    if (pop) begin
      rd_ptr_d = (rd_ptr_q == $clog2(DEPTH)'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
    end
    // push and pop in one cycle leave the count unchanged, nothing is lost
    cnt_d = cnt_q + {{$clog2(DEPTH){1'b0}}, push} - {{$clog2(DEPTH){1'b0}}, pop};
    if (!rx_en) begin
      cnt_d = '0; // see RQ4
      rd_ptr_d = '0;
      wr_ptr_d = '0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        fifo_q[i] <= '0;
      end
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      cnt_q <= cnt_d;
      for (int i = 0; i < DEPTH; i++) begin
        fifo_q[i] <= fifo_d[i];
      end
    end
  end

  // ==========================================
  // register port: writes, registered read data and the interrupt line
  always_comb begin
    ctrl_b_d = ctrl_b_q;
    ctrl_c_d = ctrl_c_q;
    rdata_d = 8'h00;
    if (WR && ADDR == `URB_OFS_CTRL_B) begin
      // the ninth received bit is read only
      ctrl_b_d = WDATA & ~(8'h01 << `URB_CB_RX_NINTH);
    end
    if (WR && ADDR == `URB_OFS_CTRL_C) begin
      ctrl_c_d = WDATA;
    end
    // status writes change nothing, so error flags stay intact, see RQ7
    if (RD) begin
      case (ADDR)
        `URB_OFS_STATUS: begin
          rdata_d[`URB_ST_RXC] = nonempty; // see RQ3
          rdata_d[`URB_ST_FRAME_ERR] = nonempty && head.frame_err;
          rdata_d[`URB_ST_OVERRUN] = nonempty && head.overrun;
          rdata_d[`URB_ST_PAR_ERR] = nonempty && head.par_err && par_en; // see RQ13 and RQ16
        end
        `URB_OFS_CTRL_B: begin
          rdata_d = ctrl_b_q;
          rdata_d[`URB_CB_RX_NINTH] = nonempty && head.data[8];
        end
        `URB_OFS_CTRL_C: rdata_d = ctrl_c_q;
        `URB_OFS_DATA: rdata_d = nonempty ? head.data[7:0] : 8'h00;
        default: rdata_d = 8'h00;
      endcase
    end
    // only the buffer level drives the request; error flags never do
    irq_d = ctrl_b_d[`URB_CB_RX_IRQ_EN] && (cnt_d != '0); // see RQ5 and RQ9
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      ctrl_b_q <= `URB_CB_RESET;
      ctrl_c_q <= `URB_CC_RESET;
      RDATA <= 8'h00;
      RX_IRQ <= 1'b0;
      RX_PIN_OVERRIDE <= 1'b0;
    end else begin
      ctrl_b_q <= ctrl_b_d;
      ctrl_c_q <= ctrl_c_d;
      RDATA <= rdata_d;
      RX_IRQ <= irq_d;
      RX_PIN_OVERRIDE <= ctrl_b_d[`URB_CB_RX_ENABLE]; // see RQ18
    end
  end

  // ==========================================
  // assertions
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);

  rxc_status_a: assert property (RD && ADDR == `URB_OFS_STATUS |=> RDATA[7] == ($past(cnt_q) != 0)) // see RQ3
    else $error("receive complete bit disagrees with buffer level");
  // enable is registered, so the flush shows one cycle after the control write lands
  flush_disable_a: assert property (WR && ADDR == `URB_OFS_CTRL_B && !WDATA[4] |-> ##2 cnt_q == 0) // see RQ4
    else $error("buffer not flushed on disable");
  irq_level_a: assert property (RX_IRQ |-> ctrl_b_q[7] && cnt_q != 0) // see RQ5
    else $error("interrupt without enabled pending data");
  pop_count_a: assert property (pop && !push && rx_en && !(WR && ADDR == `URB_OFS_CTRL_B)
    |=> cnt_q == $past(cnt_q) - 1) // see RQ2
    else $error("data read did not advance the buffer");
  parity_off_a: assert property (RD && ADDR == `URB_OFS_STATUS && !par_en |=> !RDATA[2]) // see RQ13
    else $error("parity error visible with checking off");
  overrun_set_a: assert property (rx_en && state_q == ST_IDLE && START_DET && hold_full_q && !push
    |=> ovr_pend_q) // see RQ11
    else $error("overrun not recorded");
  abort_frame_a: assert property (!rx_en |=> state_q == ST_IDLE && !hold_full_q) // see RQ17
    else $error("frame survived receiver disable");
  pin_release_a: assert property (##1 RX_PIN_OVERRIDE == $past(ctrl_b_d[4], 1)) // see RQ18
    else $error("pin override does not follow enable");
  stop_hold_a: assert property (rx_en && state_q == ST_STOP && BIT_STB
    |=> hold_full_q && hold_q.frame_err == !$past(BIT_VAL)) // see RQ21
    else $error("frame not moved on first stop bit");

  full_buffer_c: cover property (cnt_q == DEPTH && hold_full_q);
  overrun_c: cover property (push && ovr_pend_q);
  parity_fail_c: cover property (push && hold_q.par_err);
  push_pop_c: cover property (push && pop);
endmodule

// ==== urb_tx_model.sv ====
// remote transmitter model driving the recovered-bit side of the receiver
`timescale 1ns/1ps
module urb_tx_model (
  input wire logic clk, // system clock
  output logic start_det, // pulse: start bit seen
  output logic bit_stb, // pulse: one bit valid
  output logic bit_val // value of that bit
);
  initial begin
    start_det = 1'b0;
    bit_stb = 1'b0;
    bit_val = 1'b1;
  end
  // ==========
  // frame: data lsb first, parity if on, stop, then an optional bad second stop
  task automatic send(input logic [8:0] d, input logic par, stp, input int nb, pen, gap, st2);
    logic b;
    start_det <= 1'b1;
    @(posedge clk);
    start_det <= 1'b0;
    for (int i = 0; i < nb + pen + 1 + st2; i++) begin
      repeat (gap) @(posedge clk);
      b = (i < nb) ? d[i] : (i == nb && pen != 0) ? par : (i == nb + pen) ? stp : 1'b0;
      bit_stb <= 1'b1;
      bit_val <= b;
      @(posedge clk);
      bit_stb <= 1'b0;
      bit_val <= ~b; // released line must not keep showing the last bit
    end
  endtask
endmodule

// ==== urb_rx_buffer_tb.sv ====
// self-checking bench for the receive buffer against a queue reference
`timescale 1ns/1ps
`include "urb_params.svh"
module urb_rx_buffer_tb;
  logic SYS_CLK = 1'b0, SRST = 1'b1, WR = 1'b0, RD = 1'b0;
  logic [1:0] ADDR = 2'h0;
  logic [7:0] WDATA = 8'h00, RDATA, got, cb = 8'h00, cc = 8'h06;
  logic RX_IRQ, RX_PIN_OVERRIDE, start_det, bit_stb, bit_val;
  int n_errors = 0, cmp_count = 0, cyc = 0, hold = -1;
  int q[$];
  always #10 SYS_CLK = ~SYS_CLK;
  urb_rx_buffer #(.DEPTH(2)) dut_u (.SYS_CLK(SYS_CLK), .SRST(SRST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .START_DET(start_det), .BIT_STB(bit_stb),
    .BIT_VAL(bit_val), .RDATA(RDATA), .RX_IRQ(RX_IRQ), .RX_PIN_OVERRIDE(RX_PIN_OVERRIDE));
  urb_tx_model tx_u (.clk(SYS_CLK), .start_det(start_det), .bit_stb(bit_stb),
    .bit_val(bit_val));
  // ==========
  // checking and register bus tasks
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] g, e, input string m);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge SYS_CLK);
    WR <= 1'b0;
    if (a == `URB_OFS_CTRL_C) cc = d;
    if (a == `URB_OFS_CTRL_B) cb = d;
    if (a == `URB_OFS_CTRL_B && !d[4]) q.delete();
    if (a == `URB_OFS_CTRL_B && !d[4]) hold = -1;
  endtask
  task automatic rd(input logic [1:0] a);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    @(posedge SYS_CLK);
    got = RDATA;
  endtask
  // status and control b first, since the data read moves the buffer
  task automatic chk_st();
    int e;
    e = q.size() ? q[0] : 0;
    rd(`URB_OFS_STATUS);
    check(got, {q.size() > 0, 2'b00, e[9], e[10], e[11] & cc[5], 2'b00}, "status");
    check(RX_IRQ, cb[7] & (q.size() > 0), "irq");
    rd(`URB_OFS_CTRL_B);
    check(got, {cb[7], 2'b00, cb[4], 1'b0, cb[2], e[8], cb[0]}, "ctrl b");
  endtask
  task automatic pop();
    int e;
    e = q.size() ? q.pop_front() : 0;
    rd(`URB_OFS_DATA);
    check(got, e[7:0], "data");
    if (hold >= 0) q.push_back(hold);
    hold = -1;
  endtask
  // reference: two entries, one waiting frame, a fourth start marks the waiting one
  task automatic frame(input logic bad, stp);
    logic [8:0] d;
    int nb, e;
    nb = ({cb[2], cc[2:1]} == `URB_CSZ_NINE) ? 9 : 5 + cc[2:1];
    d = 9'($urandom) & 9'((1 << nb) - 1);
    e = int'(d) | (int'(!stp) << 9) | (int'(bad & cc[5]) << 11);
    tx_u.send(d, ^d ^ cc[4] ^ bad, stp, nb, cc[5], 1 + $urandom % 3, $urandom % 2);
    if (hold >= 0) hold = hold | (1 << 10);
    else if (q.size() < 2) q.push_back(e);
    else hold = e;
    repeat (3) @(posedge SYS_CLK);
  endtask
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end
  // ==========
  // main sequence
  initial begin
    logic [7:0] modes[4] = '{8'h06, 8'h16, 8'h26, 8'h36};
    void'($urandom(32'hf296500b));
    repeat (12) @(posedge SYS_CLK);
    SRST <= 1'b0;
    @(posedge SYS_CLK);
    check(RX_PIN_OVERRIDE, 1'b0, "pin idle");
    rd(`URB_OFS_CTRL_C);
    check(got, `URB_CC_RESET, "ctrl c");
    // error flag positions written as zero, every other status bit as one
    wr(`URB_OFS_STATUS, 8'hE3);
    chk_st();
    pop();
    $display("test reset done");
    wr(`URB_OFS_CTRL_B, 8'h90);
    @(posedge SYS_CLK);
    check(RX_PIN_OVERRIDE, 1'b1, "pin owned");
    for (int k = 0; k < 4; k++) frame(1'b0, k != 1);
    repeat (4) begin
      chk_st();
      pop();
    end
    frame(1'b0, 1'b1);
    chk_st();
    pop();
    $display("test overrun done");
    foreach (modes[i]) begin
      wr(`URB_OFS_CTRL_C, modes[i]);
      wr(`URB_OFS_CTRL_B, {i[0], 7'h10});
      frame(1'b0, 1'b1);
      frame(1'b1, 1'b1);
      repeat (2) begin
        chk_st();
        pop();
      end
    end
    $display("test parity done");
    for (int s = 0; s < 5; s++) begin
      wr(`URB_OFS_CTRL_C, {5'h00, 2'(s > 3 ? 3 : s), 1'b0});
      wr(`URB_OFS_CTRL_B, s == 4 ? 8'h94 : 8'h90);
      frame(1'b0, 1'b1);
      frame(1'b0, 1'b1);
      repeat (2) begin
        chk_st();
        pop();
      end
    end
    $display("test sizes done");
    frame(1'b0, 1'b1);
    fork
      tx_u.send(9'h0A5, 1'b0, 1'b1, 8, 0, 4, 0);
      begin
        repeat (10) @(posedge SYS_CLK);
        wr(`URB_OFS_CTRL_B, 8'h80);
        repeat (2) @(posedge SYS_CLK);
        check(RX_PIN_OVERRIDE, 1'b0, "pin freed");
      end
    join
    chk_st();
    wr(`URB_OFS_CTRL_B, 8'h90);
    frame(1'b0, 1'b1);
    chk_st();
    pop();
    $display("test disable done");
    final_report();
  end
endmodule
